// *** shared/brwc_params.svh ***
/*
 * Constants of the burst ROM wait controller: register offsets, field
 * positions, reset values and bus widths.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef BRWC_PARAMS_SVH
`define BRWC_PARAMS_SVH

// ==========================================================
// bus
`define BRWC_ADDR_W        12
`define BRWC_DATA_W        32

// ==========================================================
// register byte offsets
`define BRWC_CFG_OFS       12'h000
`define BRWC_STAT_OFS      12'h004

// ==========================================================
// configuration fields
`define BRWC_GAP_HI        17
`define BRWC_GAP_LO        16
`define BRWC_FIRST_HI      10
`define BRWC_FIRST_LO      7
`define BRWC_IGN_BIT       6
`define BRWC_CFG_MASK      32'h0003_07c0
`define BRWC_CFG_RST       32'h0000_0500
`define BRWC_FIRST_RST     4'ha
`define BRWC_GAP_RST       2'h0
`define BRWC_IGN_RST       1'b0

// ==========================================================
// status fields
`define BRWC_ST_BUSY       0
`define BRWC_ST_STRETCH    1
`define BRWC_ST_BADCODE    2
`define BRWC_ST_WAITLVL    3
`define BRWC_ST_CNT_LO     8
`define BRWC_ST_CNT_HI     15

// ==========================================================
// counters
`define BRWC_CNT_W         5
`define BRWC_BEAT_W        3

`endif

// *** shared/brwc_pkg.sv ***
/*
 * Types and decode functions of the burst ROM wait controller.
 * Assumes brwc_params.svh on the include path.
 */
`include "brwc_params.svh"

package brwc_pkg;

	typedef enum logic [1:0] {
		BRWC_IDLE,
		BRWC_ACCESS,
		BRWC_GAP
	} brwc_state_t;

	typedef logic [`BRWC_CNT_W-1:0] brwc_cnt_t;

	// first access wait code to cycles; forbidden codes run as longest
	function automatic brwc_cnt_t brwc_first_cycles(input logic [3:0] code);
		brwc_cnt_t n;
		n = 5'h18;
		case (code)
			4'h0: n = 5'h00;
			4'h1: n = 5'h01;
			4'h2: n = 5'h02;
			4'h3: n = 5'h03;
			4'h4: n = 5'h04;
			4'h5: n = 5'h05;
			4'h6: n = 5'h06;
			4'h7: n = 5'h08;
			4'h8: n = 5'h0a;
			4'h9: n = 5'h0c;
			4'ha: n = 5'h0e;
			4'hb: n = 5'h12;
			4'hc: n = 5'h18;
			default: n = 5'h18;
		endcase
		return n;
	endfunction

	function automatic logic brwc_code_bad(input logic [3:0] code);
		return code > 4'hc;
	endfunction

endpackage

// *** rtl/brwc_sync.sv ***
/*
 * Three-stage synchroniser for one pin; the output level changes only
 * once the second and third stages agree.
 * Assumes the pin is asynchronous to clk.
 */
`timescale 1ns/100ps

module brwc_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic pinIn,
	input  wire logic resetLevel,
	output logic      level
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s1 <= resetLevel;
			s2 <= resetLevel;
			s3 <= resetLevel;
		end else begin
			s1 <= pinIn;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			level <= resetLevel;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end

endmodule // brwc_sync

// *** rtl/brwc_wait_cnt.sv ***
/*
 * Down counter of wait cycles; loads a count and reports when it has
 * run out.
 * Assumes load and run come from the same clock domain.
 */
`timescale 1ns/100ps

module brwc_wait_cnt
	import brwc_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      resetn,
	input  wire logic      load,
	input  wire brwc_cnt_t loadVal,
	input  wire logic      run,
	output logic           elapsed
);
	brwc_cnt_t cnt;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt <= '0;
		end else if (load) begin
			cnt <= loadVal;
		end else if (run && cnt != '0) begin
			cnt <= cnt - 5'h01;
		end
	end

	assign elapsed = (cnt == '0);

endmodule // brwc_wait_cnt

// *** rtl/brwc_top.sv ***
/*
 * Burst ROM wait controller for chip-select area 0: an APB register file
 * holding the wait configuration and status, and the access sequencer
 * that inserts first-access waits, burst gap waits and external stretch.
 * Assumes an APB master on clk, a user port that requests accesses, and
 * an active-low wait pin from the ROM side, asynchronous to clk.
 */
// Contract
// R1: burst gap field gives 0..3 later-beat waits
// R2: first field gives listed first-beat wait counts
// R3: honour wait pin only while ignore bit clear
// R4: wait pin also stretches zero-wait accesses
// R5: reserved bits read zero, software writes zero
// R6: reset: first field 1010, others zero
// R7: waits in bus clocks, stretch after programmed
`timescale 1ns/100ps
`include "brwc_params.svh"

module brwc_top
	import brwc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`BRWC_ADDR_W-1:0] paddr,
	input  wire logic [`BRWC_DATA_W-1:0] pwdata,
	output logic [`BRWC_DATA_W-1:0]      prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   accReq,
	input  wire logic                   accWrite,
	input  wire logic [`BRWC_BEAT_W-1:0] accBeats,
	output logic                        accAck,
	output logic                        beatStrobe,
	output logic                        accDone,
	output logic                        busy,
	output logic                        romCsn,
	output logic                        romRdn,
	output logic                        romWen,
	input  wire logic                   extWaitn
);
	// ==========================================================
	// configuration register
	logic [1:0]                burst_gap_wait;
	logic [3:0]                first_access_wait;
	logic                      ext_wait_ignore;
	logic                      stretchSeen;
	logic                      badCode;
	logic [7:0]                accCount;
	logic                      extWaitLvl;
	logic                      waitActive;
	brwc_state_t               state;
	brwc_state_t               next_state;
	logic [`BRWC_BEAT_W-1:0]   beatsLeft;
	logic                      writeAcc;
	logic                      cntLoad;
	brwc_cnt_t                 cntVal;
	logic                      cntElapsed;
	logic                      beatDone;
	logic                      apbWrite;
	logic                      apbRead;
	logic                      hitCfg;
	logic                      hitStat;
	logic [`BRWC_DATA_W-1:0]   cfgWord;
	logic [`BRWC_DATA_W-1:0]   statWord;

	assign apbWrite = psel && penable && pwrite;
	assign apbRead  = psel && penable && !pwrite;
	assign pready   = 1'b1;

	always_comb begin
		hitCfg  = 1'b0;
		hitStat = 1'b0;
		if (paddr == `BRWC_CFG_OFS) begin
			hitCfg = 1'b1;
		end else if (paddr == `BRWC_STAT_OFS) begin
			hitStat = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			first_access_wait <= `BRWC_FIRST_RST; // R6
			burst_gap_wait    <= `BRWC_GAP_RST; // R6
			ext_wait_ignore   <= `BRWC_IGN_RST; // R6
		end else if (apbWrite && hitCfg) begin
			first_access_wait <= pwdata[`BRWC_FIRST_HI:`BRWC_FIRST_LO];
			burst_gap_wait    <= pwdata[`BRWC_GAP_HI:`BRWC_GAP_LO];
			ext_wait_ignore   <= pwdata[`BRWC_IGN_BIT];
		end
	end

	// reserved positions stay zero whatever software writes
	always_comb begin
		cfgWord = '0; // R5
		cfgWord[`BRWC_FIRST_HI:`BRWC_FIRST_LO] = first_access_wait;
		cfgWord[`BRWC_GAP_HI:`BRWC_GAP_LO]     = burst_gap_wait;
		cfgWord[`BRWC_IGN_BIT]                 = ext_wait_ignore;
	end

	always_comb begin
		statWord = '0;
		statWord[`BRWC_ST_BUSY]                   = busy;
		statWord[`BRWC_ST_STRETCH]                = stretchSeen;
		statWord[`BRWC_ST_BADCODE]                = badCode;
		statWord[`BRWC_ST_WAITLVL]                = !extWaitLvl;
		statWord[`BRWC_ST_CNT_HI:`BRWC_ST_CNT_LO] = accCount;
	end

	// ==========================================================
	// apb read data and error answer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			if (hitCfg) begin
				prdata <= cfgWord;
			end else if (hitStat) begin
				prdata <= statWord;
			end else begin
				prdata <= '0;
			end
		end
	end

	assign pslverr = psel && penable && !hitCfg && !hitStat;

	// ==========================================================
	// external wait pin
	brwc_sync u_sync (
		.clk        (clk),
		.resetn     (resetn),
		.pinIn      (extWaitn),
		.resetLevel (1'b1),
		.level      (extWaitLvl)
	);

	// unmasked pin counts even with zero programmed waits
	assign waitActive = !extWaitLvl && !ext_wait_ignore; // R3 R4

	// ==========================================================
	// wait counter
	always_comb begin
		cntLoad = 1'b0;
		cntVal  = '0;
		if (state == BRWC_IDLE && accReq) begin
			cntLoad = 1'b1;
			cntVal  = brwc_first_cycles(first_access_wait); // R2
		end else if (beatDone && beatsLeft != '0) begin
			cntLoad = 1'b1;
			// gap state also spends the zero-count cycle, so load one less
			if (burst_gap_wait != 2'h0) begin
				cntVal = {3'h0, burst_gap_wait - 2'h1}; // R1
			end
		end
	end

	brwc_wait_cnt u_cnt (
		.clk     (clk),
		.resetn  (resetn),
		.load    (cntLoad),
		.loadVal (cntVal),
		.run     (state != BRWC_IDLE), // R7
		.elapsed (cntElapsed)
	);

	// stretch looked at only once programmed waits are over
	assign beatDone = (state == BRWC_ACCESS) && cntElapsed
		&& !waitActive; // R7 R3

	// ==========================================================
	// access sequencer
	always_comb begin
		next_state = state;
		case (state)
			BRWC_IDLE: begin
				if (accReq) begin
					next_state = BRWC_ACCESS;
				end
			end
			BRWC_ACCESS: begin
				if (beatDone) begin
					if (beatsLeft == '0) begin
						next_state = BRWC_IDLE;
					end else if (burst_gap_wait == 2'h0) begin
						next_state = BRWC_ACCESS; // R1
					end else begin
						next_state = BRWC_GAP; // R1
					end
				end
			end
			BRWC_GAP: begin
				if (cntElapsed) begin
					next_state = BRWC_ACCESS; // R1
				end
			end
			default: begin
				next_state = BRWC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= BRWC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign accAck = (state == BRWC_IDLE);
	assign busy   = (state != BRWC_IDLE);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			beatsLeft <= '0;
			writeAcc  <= 1'b0;
		end else if (state == BRWC_IDLE && accReq) begin
			beatsLeft <= accBeats;
			writeAcc  <= accWrite;
		end else if (beatDone && beatsLeft != '0) begin
			beatsLeft <= beatsLeft - 3'h1;
		end
	end

	// ==========================================================
	// pin strobes and completion pulses
	always_ff @(posedge clk) begin
		if (!resetn) begin
			romCsn <= 1'b1;
			romRdn <= 1'b1;
			romWen <= 1'b1;
		end else begin
			romCsn <= (next_state == BRWC_IDLE);
			romRdn <= !(next_state == BRWC_ACCESS &&
				!(state == BRWC_IDLE ? accWrite : writeAcc));
			romWen <= !(next_state == BRWC_ACCESS &&
				(state == BRWC_IDLE ? accWrite : writeAcc));
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			beatStrobe <= 1'b0;
			accDone    <= 1'b0;
		end else begin
			beatStrobe <= beatDone;
			accDone    <= beatDone && beatsLeft == '0;
		end
	end

	// ==========================================================
	// status: stretch flag, code check, access count
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stretchSeen <= 1'b0;
		end else if (state == BRWC_ACCESS && cntElapsed && waitActive) begin
			stretchSeen <= 1'b1;
		end else if (apbWrite && hitStat && pwdata[`BRWC_ST_STRETCH]) begin
			stretchSeen <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			badCode <= 1'b0;
		end else begin
			badCode <= brwc_code_bad(first_access_wait);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			accCount <= '0;
		end else if (beatDone && beatsLeft == '0) begin
			accCount <= accCount + 8'h01;
		end
	end

endmodule // brwc_top

// *** dv/brwc_chk.sv ***
/* Port checker of the burst ROM wait controller.
   Assumes binding onto brwc_top, one clock domain. */
`timescale 1ns/100ps
module brwc_chk (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        accReq,
	input wire logic        accAck,
	input wire logic        beatStrobe,
	input wire logic        accDone,
	input wire logic        romCsn
);
	// ==========================================================
	// shadow of the wait settings
	int         tab [16] = '{0,1,2,3,4,5,6,8,10,12,14,18,24,24,24,24};
	logic [3:0] code;
	logic [1:0] gap;
	logic       ign;
	logic       first;
	int         cyc;
	wire        take = accReq && accAck;
	wire        rdCfg = psel && penable && !pwrite && paddr == 12'h000;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			code <= 4'ha;
			gap <= 2'h0;
			ign <= 1'b0;
		end else if (psel && penable && pwrite && paddr == 12'h000) begin
			code <= pwdata[10:7];
			gap <= pwdata[17:16];
			ign <= pwdata[6];
		end
	end
	// cycles since take or last beat
	always_ff @(posedge clk) begin
		cyc <= (take || beatStrobe) ? 0 : cyc + 1;
		first <= resetn && (take || (first && !beatStrobe));
	end
	// ==========================================================
	// assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_first_wait:
		assert property (beatStrobe && first && ign |-> cyc == tab[code] + 1)
		else $error("first beat wait wrong");
	a_gap_wait:
		assert property (beatStrobe && !first && ign |-> cyc == gap)
		else $error("burst gap wait wrong");
	a_cs_early:
		assert property (take |=> !romCsn && !beatStrobe)
		else $error("access start wrong");
	a_cs_held:
		assert property (beatStrobe && !accDone |-> !romCsn)
		else $error("chip select dropped in burst");
	a_done_beat:
		assert property (accDone |-> beatStrobe)
		else $error("done without beat");
	a_rsv_zero:
		assert property (rdCfg |-> (prdata & 32'hfffc_f83f) == 32'h0)
		else $error("reserved bits not zero");
	a_cfg_value:
		assert property (rdCfg |-> prdata[17:6] == {gap, 5'h0, code, ign})
		else $error("config readback wrong");
	a_bad_addr:
		assert property (psel && penable && paddr > 12'h004 |-> pslverr)
		else $error("unmapped access accepted");
endmodule // brwc_chk

bind brwc_top brwc_chk u_brwc_chk (.clk, .resetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pslverr, .accReq, .accAck, .beatStrobe,
	.accDone, .romCsn);

// *** dv/brwc_rom_model.sv ***
/* Far-side ROM: holds the wait pin low for holdCycles after select.
   Assumes a pull-up on the pin while released. */
`timescale 1ns/100ps
module brwc_rom_model (
	input  wire logic clk,
	input  wire logic romCsn,
	input  wire logic [31:0] holdCycles,
	output logic      extWaitn
);
	int left;
	initial extWaitn = 1'b1;
	always @(posedge clk) begin
		if (romCsn) begin
			left = int'(holdCycles);
			extWaitn <= 1'b1;
		end else begin
			extWaitn <= (left <= 0);
			left = left - 1;
		end
	end
endmodule // brwc_rom_model

// *** dv/testbench.sv ***
/* Self-checking bench of the burst ROM wait controller.
   Assumes brwc_top, brwc_rom_model and the bound checker. */
`timescale 1ns/100ps
module testbench import brwc_pkg::*;;
	logic        clk, resetn, psel, penable, pwrite, accReq, accWrite;
	logic        pready, pslverr, accAck, beatStrobe, accDone, busy;
	logic        romCsn, romRdn, romWen, extWaitn, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, r;
	logic [31:0] seed = 32'h0000_87df;
	logic [2:0]  accBeats;
	int          holdCycles, n_mismatch, compares, t, base;
	int          tab [16] = '{0,1,2,3,4,5,6,8,10,12,14,18,24,24,24,24};
	int          expq [$];
	brwc_top u_brwc_top (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .accReq, .accWrite, .accBeats,
		.accAck, .beatStrobe, .accDone, .busy, .romCsn, .romRdn, .romWen,
		.extWaitn);
	brwc_rom_model u_brwc_rom_model (.clk, .romCsn, .holdCycles, .extWaitn);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic fail(input string m);
		n_mismatch++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic chk_reg(input logic [31:0] g, e, input string m);
		compares++;
		if (g !== e) fail(m);
	endtask
	task automatic chk_cyc(input int g, e, input string m);
		compares++;
		if (g != e) fail(m);
	endtask
	task automatic chk_pin(input logic g, e, input string m);
		compares++;
		if (g !== e) fail(m);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fail("apb hang");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// model: beat k ends at first wait + 2 + k * (gap + 1)
	task automatic run_acc(input logic [3:0] c, input logic [1:0] g,
		input logic i, input int hold, input logic [2:0] b, input logic ex,
		output int last);
		int n;
		int act;
		logic wr;
		apb(1'b1, 12'h000, {14'h0, g, 5'h0, c, i, 6'h0});
		holdCycles <= hold;
		expq.delete();
		for (n = 0; n <= b; n++)
			expq.push_back(tab[c] + 2 + n * (g + 1));
		r = rnd();
		wr = r[0];
		accWrite <= r[0];
		accBeats <= b;
		accReq <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (accAck !== 1'b1 && n < 50);
		if (accAck !== 1'b1) fail("ack hang");
		accReq <= 1'b0;
		n = 0;
		act = 0;
		do begin
			@(posedge clk);
			n++;
			chk_pin(romCsn, accDone, "chip select");
			chk_pin(busy, !accDone, "busy");
			chk_pin(accAck, accDone, "ack");
			chk_pin(wr ? romRdn : romWen, 1'b1, "idle strobe");
			if ((wr ? romWen : romRdn) === 1'b0) act++;
			if (beatStrobe === 1'b1) begin
				last = n;
				if (ex) chk_cyc(n, expq.pop_front(), "beat time");
			end
		end while (accDone !== 1'b1 && n < 300);
		if (accDone !== 1'b1) fail("access hang");
		if (ex) chk_cyc(expq.size(), 0, "beat count");
		if (ex) chk_cyc(act, tab[c] + 1 + b, "strobe cycles");
	endtask
	// ==========================================================
	// tests
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		accReq = 1'b0;
		accWrite = 1'b0;
		accBeats = 3'h0;
		holdCycles = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		apb(1'b0, 12'h000, 32'h0);
		chk_reg(rd, 32'h0000_0500, "config reset");
		apb(1'b1, 12'h000, 32'h0003_07c0);
		apb(1'b0, 12'h000, 32'h0);
		chk_reg(rd, 32'h0003_07c0, "all fields");
		apb(1'b0, 12'h004, 32'h0);
		chk_reg(rd, 32'h0000_0004, "status idle");
		apb(1'b0, 12'h010, 32'h0);
		chk_reg({31'h0, err}, 32'h1, "unmapped");
		$display("register test done");
		for (int c = 0; c < 16; c++) begin
			r = rnd();
			run_acc(c[3:0], r[1:0], 1'b1, int'(r[7:4]), r[10:8], 1'b1, t);
		end
		$display("wait code test done");
		run_acc(4'h0, 2'h3, 1'b0, 0, 3'h7, 1'b1, base);
		run_acc(4'h0, 2'h3, 1'b0, 20, 3'h7, 1'b0, t);
		chk_cyc(int'(t > base), 1, "no stretch");
		apb(1'b0, 12'h004, 32'h0);
		chk_reg(rd, 32'h0000_1202, "status stretch");
		apb(1'b1, 12'h004, 32'h0000_0002);
		apb(1'b0, 12'h004, 32'h0);
		chk_reg(rd, 32'h0000_1200, "status cleared");
		$display("wait pin test done");
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		apb(1'b0, 12'h000, 32'h0);
		chk_reg(rd, 32'h0000_0500, "config reset again");
		$display("reset test done");
		end_sim();
	end
	initial begin
		#50000;
		fail("watchdog expired");
		end_sim();
	end
endmodule // testbench
